// File: core/rtck_core.sv
// Contract
// - setting run enable starts crystal amplifier and counting
// - clearing run enable stops counting at once, settings kept
// - setting run enable again resumes from held values
// - time counters at FAh..FFh with documented widths
// - time reads need read unlock, writes need write unlock
// - unlock suspends updates at most 1.95 ms, then window closes
// - tick during suspension is held and applied when unlock clears
// - ticks every 3.90625 ms; first after write unlock falls is half
// - subsecond ignores writes, cleared when write unlock falls
// - write unlock changes only through completed timed unlock or window timeout
// - control register F9h bit layout
// - calibration at 96h; tick-out and trim need timed unlock
// - alarm registers F2h..F5h, always writable
// - alarm irq enable and priority at bit 5, reset 0
// - time, alarm and most control survive processor reset
// - written time values are not validated
// - alarm raises interrupt and wakes from stop
// - weekday counts on hour wrap, 7 to 1, zero frozen
// - all match enables clear disables alarm and clears flag
`timescale 1ns/10ps
module rtck_core
    import rtck_pkg::*;
#(
    parameter int WINDOW_CYCLES_P = rtck_pkg::WINDOW_CYCLES
)
(
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic       xtal_in,
    input  wire logic [7:0] sfr_addr_in,
    input  wire logic       sfr_wr_in,
    input  wire logic       sfr_rd_in,
    input  wire logic [7:0] sfr_wdata_in,
    output logic [7:0]      sfr_rdata_out,
    output logic            xtal_amp_en_out,
    output logic            tick4k_out,
    output logic            alarm_irq_out,
    output logic            alarm_irq_priority_out,
    output logic            stop_wake_out
);
    localparam int WW = $clog2(WINDOW_CYCLES_P + 1);
    localparam int TW = $clog2(TA_SPAN_CYCLES + 1);

    logic [1:0]    rst_sync_reg;
    logic          rst_n;
    rtck_ta_t      ta_reg, ta_next;
    logic [TW-1:0] ta_cnt_reg, ta_cnt_next;
    logic          rul_reg, rul_next;
    logic          wul_reg, wul_next;
    logic [WW-1:0] win_reg, win_next;
    logic          pend_reg, pend_next;
    logic          applied_reg, applied_next;
    logic          ien_reg, ien_next;
    logic          ipr_reg, ipr_next;
    logic          tko_reg, tko_next;
    logic [7:0]    rdata_reg, rdata_next;
    logic          run_reg, run_next;
    logic          flag_reg, flag_next;
    logic [3:0]    me_reg, me_next;
    logic [6:0]    cal_reg, cal_next;
    logic [7:0]    al_ss_reg, al_ss_next;
    logic [7:0]    al_sec_reg, al_sec_next;
    logic [7:0]    al_min_reg, al_min_next;
    logic [7:0]    al_hr_reg, al_hr_next;
    logic          susp;
    logic          ta_open;
    logic          wr_ctl;
    logic          wr_cal;
    logic          wr_ta;
    logic          hit;
    logic          trim_ok;
    logic [7:0]    ctl_view;

    rtck_if tk ();

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            rst_sync_reg <= 2'b00;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    assign wr_ctl  = sfr_wr_in && (sfr_addr_in == ADDR_CTL);
    assign wr_cal  = sfr_wr_in && (sfr_addr_in == ADDR_CAL);
    assign wr_ta   = sfr_wr_in && (sfr_addr_in == ADDR_TA);
    assign ta_open = (ta_reg == TA_OPEN);
    assign susp    = rul_reg | wul_reg;
    assign ctl_view = {me_reg, rul_reg, wul_reg, flag_reg, run_reg};

    always_comb
    begin
        ta_next = ta_reg;
        ta_cnt_next = ta_cnt_reg + TW'(1);
        case (ta_reg)
            TA_IDLE:
            begin
                ta_cnt_next = '0;
            end
            TA_KEYED:
            begin
                if (wr_ta && sfr_wdata_in == TA_KEY2)
                begin
                    ta_next = TA_OPEN;
                    ta_cnt_next = '0;
                end
                else if (ta_cnt_reg == TW'(TA_SPAN_CYCLES - 1))
                    ta_next = TA_IDLE;
            end
            TA_OPEN:
            begin
                // one protected write per sequence
                if (wr_ctl || wr_cal || ta_cnt_reg == TW'(TA_SPAN_CYCLES - 1))
                    ta_next = TA_IDLE;
            end
            default:
            begin
                ta_next = TA_IDLE;
            end
        endcase
        if (wr_ta && sfr_wdata_in == TA_KEY1)
        begin
            ta_next = TA_KEYED;
            ta_cnt_next = '0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ta_reg <= TA_IDLE;
            ta_cnt_reg <= '0;
        end
        else
        begin
            ta_reg <= ta_next;
            ta_cnt_reg <= ta_cnt_next;
        end
    end

    // alarm checked once per applied tick, enabled fields must all match
    assign hit = applied_reg && (me_reg != 4'h0)
        && (!me_reg[3] || tk.ss == al_ss_reg)
        && (!me_reg[2] || tk.sec == al_sec_reg)
        && (!me_reg[1] || tk.min == al_min_reg)
        && (!me_reg[0] || tk.hour[4:0] == al_hr_reg[4:0]);
    assign trim_ok = ({sfr_wdata_in[5], sfr_wdata_in[3], sfr_wdata_in[1]}
        == ~{sfr_wdata_in[4], sfr_wdata_in[2], sfr_wdata_in[0]});

    // volatile control: cleared by processor reset
    always_comb
    begin
        rul_next = rul_reg;
        wul_next = wul_reg;
        win_next = '0;
        pend_next = 1'b0;
        ien_next = ien_reg;
        ipr_next = ipr_reg;
        tko_next = tko_reg;
        rdata_next = rdata_reg;
        applied_next = tk.apply;
        if (wr_ctl)
        begin
            rul_next = sfr_wdata_in[CTL_RUL];
            if (ta_open)
                wul_next = sfr_wdata_in[CTL_WUL];
        end
        if (susp)
        begin
            win_next = win_reg + WW'(1);
            if (win_reg == WW'(WINDOW_CYCLES_P - 1))
            begin
                rul_next = 1'b0;
                wul_next = 1'b0;
                win_next = '0;
            end
        end
        if (susp)
            pend_next = pend_reg | tk.tick;
        if (sfr_wr_in && sfr_addr_in == ADDR_XIE)
            ien_next = sfr_wdata_in[XIRQ_BIT];
        if (sfr_wr_in && sfr_addr_in == ADDR_XIP)
            ipr_next = sfr_wdata_in[XIRQ_BIT];
        if (wr_cal && ta_open)
            tko_next = sfr_wdata_in[CAL_TICK_OUT] & trim_ok;
        if (sfr_rd_in)
        begin
            case (sfr_addr_in)
                ADDR_CAL:    rdata_next = {tko_reg, cal_reg};
                ADDR_XIE:    rdata_next = 8'(ien_reg) << XIRQ_BIT;
                ADDR_XIP:    rdata_next = 8'(ipr_reg) << XIRQ_BIT;
                ADDR_AL_SS:  rdata_next = al_ss_reg;
                ADDR_AL_SEC: rdata_next = al_sec_reg;
                ADDR_AL_MIN: rdata_next = al_min_reg;
                ADDR_AL_HR:  rdata_next = al_hr_reg;
                ADDR_CTL:    rdata_next = ctl_view;
                ADDR_SS:     rdata_next = rul_reg ? tk.ss : 8'h00;
                ADDR_SEC:    rdata_next = rul_reg ? tk.sec : 8'h00;
                ADDR_MIN:    rdata_next = rul_reg ? tk.min : 8'h00;
                ADDR_HR:     rdata_next = rul_reg ? tk.hour : 8'h00;
                ADDR_DAY_LO: rdata_next = rul_reg ? tk.day[7:0] : 8'h00;
                ADDR_DAY_HI: rdata_next = rul_reg ? tk.day[15:8] : 8'h00;
                default:     rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rul_reg <= 1'b0;
            wul_reg <= 1'b0;
            win_reg <= '0;
            pend_reg <= 1'b0;
            applied_reg <= 1'b0;
            ien_reg <= 1'b0;
            ipr_reg <= 1'b0;
            tko_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end
        else
        begin
            rul_reg <= rul_next;
            wul_reg <= wul_next;
            win_reg <= win_next;
            pend_reg <= pend_next;
            applied_reg <= applied_next;
            ien_reg <= ien_next;
            ipr_reg <= ipr_next;
            tko_reg <= tko_next;
            rdata_reg <= rdata_next;
        end
    end

    // battery-backed control and alarm state
    always_comb
    begin
        run_next = run_reg;
        flag_next = flag_reg;
        me_next = me_reg;
        cal_next = cal_reg;
        al_ss_next = al_ss_reg;
        al_sec_next = al_sec_reg;
        al_min_next = al_min_reg;
        al_hr_next = al_hr_reg;
        if (wr_ctl)
        begin
            me_next = sfr_wdata_in[CTL_ME_HI:CTL_ME_LO];
            flag_next = sfr_wdata_in[CTL_FLAG];
            run_next = sfr_wdata_in[CTL_RUN];
        end
        // hardware set wins over a software clear
        if (hit)
            flag_next = 1'b1;
        if (me_next == 4'h0)
            flag_next = 1'b0;
        if (wr_cal)
        begin
            cal_next[CAL_LOAD] = sfr_wdata_in[CAL_LOAD];
            if (ta_open)
                cal_next[5:0] = trim_ok ? sfr_wdata_in[5:0] : CAL_TRIM_FALLBACK;
        end
        if (sfr_wr_in)
        begin
            case (sfr_addr_in)
                ADDR_AL_SS:  al_ss_next = sfr_wdata_in;
                ADDR_AL_SEC: al_sec_next = sfr_wdata_in;
                ADDR_AL_MIN: al_min_next = sfr_wdata_in;
                ADDR_AL_HR:  al_hr_next = sfr_wdata_in;
                default:     al_ss_next = al_ss_next;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        run_reg <= run_next;
        flag_reg <= flag_next;
        me_reg <= me_next;
        cal_reg <= cal_next;
        al_ss_reg <= al_ss_next;
        al_sec_reg <= al_sec_next;
        al_min_reg <= al_min_next;
        al_hr_reg <= al_hr_next;
    end

    assign tk.run = run_reg;
    // half interval after write unlock falls
    assign tk.restart_half = wul_reg & ~wul_next;
    assign tk.clr_ss = wul_reg & ~wul_next;
    assign tk.apply = ~susp & (pend_reg | tk.tick);
    assign tk.wr_en = sfr_wr_in && wul_reg && (sfr_addr_in[7:3] == ADDR_SS[7:3])
        && (sfr_addr_in[2:0] >= ADDR_SEC[2:0]);
    assign tk.wr_idx = sfr_addr_in[2:0];
    assign tk.wdata = sfr_wdata_in;

    rtck_tick_gen u_tick (
        .clk_in         (clk_in),
        .rst_n_in       (rst_n),
        .xtal_in        (xtal_in),
        .tick_out_en_in (tko_reg),
        .tick4k_out     (tick4k_out),
        .tk             (tk.tick_src)
    );

    rtck_time_count u_time (
        .clk_in (clk_in),
        .tk     (tk.cnt_core)
    );

    assign sfr_rdata_out = rdata_reg;
    assign xtal_amp_en_out = run_reg;
    assign alarm_irq_out = flag_reg & ien_reg;
    assign alarm_irq_priority_out = ipr_reg;
    assign stop_wake_out = flag_reg & ien_reg;
endmodule

// File: pkg/rtck_pkg.sv
package rtck_pkg;
    // register map
    localparam logic [7:0] ADDR_CAL    = 8'h96;
    localparam logic [7:0] ADDR_TA     = 8'hC7;
    localparam logic [7:0] ADDR_XIE    = 8'hE8;
    localparam logic [7:0] ADDR_XIP    = 8'hF8;
    localparam logic [7:0] ADDR_AL_SS  = 8'hF2;
    localparam logic [7:0] ADDR_AL_SEC = 8'hF3;
    localparam logic [7:0] ADDR_AL_MIN = 8'hF4;
    localparam logic [7:0] ADDR_AL_HR  = 8'hF5;
    localparam logic [7:0] ADDR_CTL    = 8'hF9;
    localparam logic [7:0] ADDR_SS     = 8'hFA;
    localparam logic [7:0] ADDR_SEC    = 8'hFB;
    localparam logic [7:0] ADDR_MIN    = 8'hFC;
    localparam logic [7:0] ADDR_HR     = 8'hFD;
    localparam logic [7:0] ADDR_DAY_LO = 8'hFE;
    localparam logic [7:0] ADDR_DAY_HI = 8'hFF;
    // control register fields
    localparam int CTL_RUN  = 0;
    localparam int CTL_FLAG = 1;
    localparam int CTL_WUL  = 2;
    localparam int CTL_RUL  = 3;
    localparam int CTL_ME_LO = 4;
    localparam int CTL_ME_HI = 7;
    localparam int XIRQ_BIT = 5;
    // calibration fields
    localparam int CAL_TICK_OUT = 7;
    localparam int CAL_LOAD     = 6;
    localparam logic [5:0] CAL_TRIM_FALLBACK = 6'h25;
    // timed unlock keys
    localparam logic [7:0] TA_KEY1 = 8'hAA;
    localparam logic [7:0] TA_KEY2 = 8'h55;
    // counting limits
    localparam logic [7:0] MAX_MIN_SEC = 8'h3B;
    localparam logic [4:0] MAX_HOUR    = 5'h17;
    localparam logic [2:0] DOW_LAST    = 3'h7;
    localparam logic [2:0] DOW_FIRST   = 3'h1;
    // timing
    localparam int PRESCALE       = 128;
    localparam int PRESCALE_HALF  = 64;
    localparam int CLK_PERIOD_NS  = 20;
    localparam int WINDOW_NS      = 1950000;
    localparam int WINDOW_CYCLES  = WINDOW_NS / CLK_PERIOD_NS;
    localparam int MC_CLOCKS      = 4;
    localparam int TA_SPAN_MC     = 3;
    localparam int TA_SPAN_CYCLES = TA_SPAN_MC * MC_CLOCKS;

    typedef enum logic [1:0] {
        TA_IDLE  = 2'b00,
        TA_KEYED = 2'b01,
        TA_OPEN  = 2'b10
    } rtck_ta_t;
endpackage

// File: pkg/rtck_if.sv
`timescale 1ns/10ps
interface rtck_if;
    logic        tick;
    logic        run;
    logic        restart_half;
    logic        apply;
    logic        clr_ss;
    logic        wr_en;
    logic [2:0]  wr_idx;
    logic [7:0]  wdata;
    logic [7:0]  ss;
    logic [7:0]  sec;
    logic [7:0]  min;
    logic [7:0]  hour;
    logic [15:0] day;

    modport tick_src (input run, input restart_half, output tick);
    modport tick_dst (output run, output restart_half, input tick);
    modport cnt_core (input apply, input clr_ss, input wr_en, input wr_idx, input wdata,
                      output ss, output sec, output min, output hour, output day);
    modport cnt_ctl  (output apply, output clr_ss, output wr_en, output wr_idx, output wdata,
                      input ss, input sec, input min, input hour, input day);
endinterface

// File: core/rtck_tick_gen.sv
`timescale 1ns/10ps
module rtck_tick_gen
    import rtck_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic xtal_in,
    input  wire logic tick_out_en_in,
    output logic      tick4k_out,
    rtck_if.tick_src  tk
);
    logic [2:0] sync_reg;
    logic [2:0] sync_next;
    logic [6:0] pre_reg;
    logic [6:0] pre_next;
    logic       tick_reg;
    logic       tick_next;
    logic       out_reg;
    logic       out_next;
    logic       rise;

    // stage 0 feeds only stage 1; edges are taken from stages 1 and 2
    assign rise = sync_reg[1] & ~sync_reg[2];

    always_comb
    begin
        sync_next = {sync_reg[1:0], xtal_in};
        pre_next  = pre_reg;
        tick_next = 1'b0;
        if (tk.restart_half)
            pre_next = 7'(PRESCALE_HALF);
        else if (tk.run && rise)
        begin
            pre_next = pre_reg + 7'h01;
            tick_next = (pre_reg == 7'(PRESCALE - 1));
        end
        out_next = tick_out_en_in & pre_reg[2];
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sync_reg <= 3'h0;
            pre_reg  <= 7'h00;
            tick_reg <= 1'b0;
            out_reg  <= 1'b0;
        end
        else
        begin
            sync_reg <= sync_next;
            pre_reg  <= pre_next;
            tick_reg <= tick_next;
            out_reg  <= out_next;
        end
    end

    assign tk.tick    = tick_reg;
    assign tick4k_out = out_reg;
endmodule

// File: core/rtck_time_count.sv
`timescale 1ns/10ps
module rtck_time_count
    import rtck_pkg::*;
(
    input  wire logic clk_in,
    rtck_if.cnt_core  tk
);
    logic [7:0]  ss_reg,  ss_next;
    logic [7:0]  sec_reg, sec_next;
    logic [7:0]  min_reg, min_next;
    logic [7:0]  hr_reg,  hr_next;
    logic [15:0] day_reg, day_next;

    // no range check: an out-of-range value simply counts on to 8-bit wrap
    function automatic logic [7:0] step_wrap(input logic [7:0] v, input logic [7:0] last);
        step_wrap = (v == last) ? 8'h00 : v + 8'h01;
    endfunction

    always_comb
    begin
        ss_next  = ss_reg;
        sec_next = sec_reg;
        min_next = min_reg;
        hr_next  = hr_reg;
        day_next = day_reg;
        if (tk.apply)
        begin
            ss_next = ss_reg + 8'h01;
            if (ss_reg == 8'hFF)
            begin
                sec_next = step_wrap(sec_reg, MAX_MIN_SEC);
                if (sec_reg == MAX_MIN_SEC)
                begin
                    min_next = step_wrap(min_reg, MAX_MIN_SEC);
                    if (min_reg == MAX_MIN_SEC)
                    begin
                        hr_next[4:0] = hr_reg[4:0] + 5'h01;
                        if (hr_reg[4:0] == MAX_HOUR)
                        begin
                            hr_next[4:0] = 5'h00;
                            day_next = day_reg + 16'h0001;
                            if (hr_reg[7:5] == DOW_LAST)
                                hr_next[7:5] = DOW_FIRST;
                            else if (hr_reg[7:5] != 3'h0)
                                hr_next[7:5] = hr_reg[7:5] + 3'h1;
                        end
                    end
                end
            end
        end
        if (tk.wr_en)
        begin
            case (tk.wr_idx)
                ADDR_SEC[2:0]:    sec_next = tk.wdata;
                ADDR_MIN[2:0]:    min_next = tk.wdata;
                ADDR_HR[2:0]:     hr_next = tk.wdata;
                ADDR_DAY_LO[2:0]: day_next[7:0] = tk.wdata;
                ADDR_DAY_HI[2:0]: day_next[15:8] = tk.wdata;
                default:          ss_next = ss_next;
            endcase
        end
        if (tk.clr_ss)
            ss_next = 8'h00;
    end

    // battery-backed: processor reset must not touch the time
    always_ff @(posedge clk_in)
    begin
        ss_reg  <= ss_next;
        sec_reg <= sec_next;
        min_reg <= min_next;
        hr_reg  <= hr_next;
        day_reg <= day_next;
    end

    assign tk.ss   = ss_reg;
    assign tk.sec  = sec_reg;
    assign tk.min  = min_reg;
    assign tk.hour = hr_reg;
    assign tk.day  = day_reg;
endmodule

// File: verif/rtck_core_asserts.sv
`timescale 1ns/10ps
module rtck_core_asserts
    import rtck_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic [7:0] sfr_addr_in,
    input  wire logic       sfr_wr_in,
    input  wire logic       sfr_rd_in,
    input  wire logic [7:0] sfr_wdata_in,
    input  wire logic [7:0] sfr_rdata_out,
    input  wire logic       xtal_amp_en_out,
    input  wire logic       tick4k_out,
    input  wire logic       alarm_irq_out,
    input  wire logic       alarm_irq_priority_out,
    input  wire logic       stop_wake_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);
    wire logic ctl_wr = sfr_wr_in && (sfr_addr_in == ADDR_CTL);

    a_wake_follows_irq: assert property (stop_wake_out == alarm_irq_out)
        else $error("stop wake differs from alarm irq");
    a_run_drives_amp: assert property (ctl_wr |=> xtal_amp_en_out == $past(sfr_wdata_in[CTL_RUN]))
        else $error("amplifier enable not following run bit");
    a_prio_write: assert property (sfr_wr_in && sfr_addr_in == ADDR_XIP
        |=> alarm_irq_priority_out == $past(sfr_wdata_in[XIRQ_BIT]))
        else $error("priority output not following write");
    a_prio_reset_low: assert property ($rose(nrst_in) |-> !alarm_irq_priority_out)
        else $error("priority not cleared by reset");
    a_irq_masked: assert property (sfr_wr_in && sfr_addr_in == ADDR_XIE && !sfr_wdata_in[XIRQ_BIT]
        |=> !alarm_irq_out)
        else $error("alarm irq while disabled");
    a_match_off_clears: assert property (ctl_wr && sfr_wdata_in[7:4] == 4'h0
        |=> !alarm_irq_out [*2])
        else $error("flag survives clearing all match enables");
    a_locked_read_zero: assert property (ctl_wr && !sfr_wdata_in[CTL_RUL]
        ##[1:2] sfr_rd_in && sfr_addr_in >= ADDR_SS |=> sfr_rdata_out == 8'h00)
        else $error("time read while locked not zero");
    a_unmapped_zero: assert property (sfr_rd_in && sfr_addr_in == 8'h00 |=> sfr_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out))
        else $error("read data changed without a read");

    c_irq_rise: cover property ($rose(alarm_irq_out));
    c_tick_out: cover property ($rose(tick4k_out));
    c_ctl_read: cover property (sfr_rd_in && sfr_addr_in == ADDR_CTL);
endmodule

// File: verif/rtck_core_tb_top.sv
`timescale 1ns/10ps
module rtck_core_tb_top;
    import rtck_pkg::*;
    logic       clk_in = 1'b0, nrst_in = 1'b0, xtal_in = 1'b0, sfr_wr_in = 1'b0, sfr_rd_in = 1'b0;
    logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, sfr_rdata_out;
    logic       xtal_amp_en_out, tick4k_out, alarm_irq_out, alarm_irq_priority_out, stop_wake_out;
    logic [7:0] tv [5] = '{8'h3B, 8'h3D, 8'h37, 8'hFF, 8'h12};
    int         errors = 0, checks = 0, cycles = 0;

    // short window keeps the unlock timeout test quick
    rtck_core #(.WINDOW_CYCLES_P(200)) u_rtck_core (.clk_in(clk_in), .nrst_in(nrst_in),
        .xtal_in(xtal_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
        .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
        .xtal_amp_en_out(xtal_amp_en_out), .tick4k_out(tick4k_out),
        .alarm_irq_out(alarm_irq_out), .alarm_irq_priority_out(alarm_irq_priority_out),
        .stop_wake_out(stop_wake_out));

    always #10 clk_in = ~clk_in;
    // crystal at 8 clocks a period: one subsecond tick every 1024 clocks
    always #80 xtal_in = ~xtal_in;
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            end_sim();
        end
    end

    task automatic end_sim;
        if (errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        sfr_addr_in = a;
        sfr_wdata_in = d;
        sfr_wr_in = 1'b1;
        @(posedge clk_in);
        #1;
        sfr_wr_in = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge clk_in);
        #1;
        sfr_addr_in = a;
        sfr_rd_in = 1'b1;
        @(posedge clk_in);
        #1;
        sfr_rd_in = 1'b0;
        check(name, sfr_rdata_out, exp);
    endtask

    // keys land two cycles apart, well inside the twelve clock span
    task automatic ta_wr(input logic [7:0] a, input logic [7:0] d);
        wr(ADDR_TA, TA_KEY1);
        wr(ADDR_TA, TA_KEY2);
        wr(a, d);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    initial
    begin
        repeat (2) @(posedge clk_in);
        #1 nrst_in = 1'b1;
        idle(3);
        check("priority", {7'h00, alarm_irq_priority_out}, 8'h00);
        check("irq", {7'h00, alarm_irq_out}, 8'h00);
        wr(ADDR_CTL, 8'h01);
        rd(ADDR_SEC, 8'h00, "locked second");
        check("amp", {7'h00, xtal_amp_en_out}, 8'h01);
        wr(ADDR_CTL, 8'h05);
        rd(ADDR_CTL, 8'h01, "ctl no key");
        rd(8'h00, 8'h00, "unmapped");
        wr(ADDR_AL_SS, 8'h05);
        wr(ADDR_XIE, 8'h20);
        wr(ADDR_XIP, 8'h20);
        check("priority", {7'h00, alarm_irq_priority_out}, 8'h01);
        ta_wr(ADDR_CTL, 8'h0D);
        idle(16);
        wr(ADDR_SS, 8'hF0);
        for (int i = 0; i < 5; i++)
            wr(8'(ADDR_SEC + i), tv[i]);
        for (int i = 0; i < 5; i++)
            rd(8'(ADDR_SEC + i), tv[i], "time");
        ta_wr(ADDR_CTL, 8'h01);
        // ticks at half, one and a half, two and a half periods
        idle(2800);
        wr(ADDR_CTL, 8'h09);
        idle(16);
        rd(ADDR_SS, 8'h03, "subsecond");
        wr(ADDR_CTL, 8'h00);
        check("amp", {7'h00, xtal_amp_en_out}, 8'h00);
        idle(2000);
        wr(ADDR_CTL, 8'h08);
        idle(16);
        rd(ADDR_SS, 8'h03, "frozen");
        rd(ADDR_AL_SS, 8'h05, "alarm kept");
        idle(220);
        rd(ADDR_CTL, 8'h00, "window");
        wr(ADDR_CTL, 8'h81);
        for (int i = 0; i < 2500 && alarm_irq_out !== 1'b1; i++)
            @(negedge clk_in);
        check("alarm", {7'h00, alarm_irq_out}, 8'h01);
        check("wake", {7'h00, stop_wake_out}, 8'h01);
        // flag bit written back as one so the pending alarm is kept
        wr(ADDR_CTL, 8'h8B);
        idle(16);
        rd(ADDR_SS, 8'h05, "resumed");
        rd(ADDR_CTL, 8'h8B, "ctl flag");
        wr(ADDR_CTL, 8'h0B);
        check("irq off", {7'h00, alarm_irq_out}, 8'h00);
        rd(ADDR_CTL, 8'h09, "flag clear");
        ta_wr(ADDR_CAL, 8'hA6);
        rd(ADDR_CAL, 8'hA6, "cal");
        for (int i = 0; i < 80 && tick4k_out !== 1'b1; i++)
            @(negedge clk_in);
        check("tick out", {7'h00, tick4k_out}, 8'h01);
        ta_wr(ADDR_CAL, 8'hC0);
        rd(ADDR_CAL, 8'h65, "cal fallback");
        idle(4);
        check("tick off", {7'h00, tick4k_out}, 8'h00);
        end_sim();
    end
endmodule

bind rtck_core rtck_core_asserts u_rtck_core_asserts (.clk_in(clk_in), .nrst_in(nrst_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
    .xtal_amp_en_out(xtal_amp_en_out), .tick4k_out(tick4k_out), .alarm_irq_out(alarm_irq_out),
    .alarm_irq_priority_out(alarm_irq_priority_out), .stop_wake_out(stop_wake_out));
